//--- hw/bds_status.sv
// debug unit status register with activation, step and security tracking
`timescale 1ns/1ps
`include "bds_regs.svh"
module bds_status
  import bds_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // mode strap and flash security state
  input wire logic i_debug_wire_pin,
  input wire logic i_flash_secured,
  // hardware register commands from the wire decoder
  input wire logic i_cmd_rx,
  input wire logic i_hw_rd,
  input wire logic i_hw_wr,
  input wire logic [17:0] i_hw_addr,
  input wire logic [7:0] i_hw_wdata,
  output logic [7:0] o_hw_rdata,
  output logic o_hw_rvalid,
  output logic o_hw_refused,
  // command progress
  input wire logic i_data_done,
  input wire logic i_bgnd_req,
  input wire logic i_step_cmd,
  input wire logic i_resume_cmd,
  // firmware stores
  input wire logic i_fw_wr,
  input wire logic [7:0] i_fw_wdata,
  input wire logic i_secfw_wr,
  input wire logic [7:0] i_secfw_wdata,
  // status toward the rest of the chip
  output logic o_debug_enable,
  output logic o_debug_active,
  output logic o_fw_table_map,
  output logic o_sec_table_map,
  output logic o_security_off,
  output logic o_special_mode,
  output logic [7:0] o_status
);

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser

  bds_sync_if pin_if ();

  assign pin_if.raw = i_debug_wire_pin;

  bds_sync u_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .sif(pin_if.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  bds_state_t st_r;
  bds_state_t st_nxt;
  logic locked;
  logic hit;
  logic [7:0] view;

  // the part counts as secured until the unsecured flag is proven
  assign locked = i_flash_secured & ~st_r.security_off_flag;
  assign hit = (i_hw_addr == `BDS_STATUS_ADDR);

  // implemented bits only; unsecured shows only on a secured part
  always_comb
  begin
    view = 8'h00;
    view[`BDS_EN_BIT] = st_r.en;
    view[`BDS_ACT_BIT] = st_r.act;
    view[`BDS_SDV_BIT] = st_r.shift_data_valid_flag;
    view[`BDS_STEP_BIT] = st_r.step;
    view[`BDS_SECURITY_OFF_FLAG_BIT] = st_r.security_off_flag & i_flash_secured;
    view = view & `BDS_IMPL_MASK;
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.refused = 1'b0;

    // strap is read only after the synchroniser has flushed its reset value
    if (!st_r.cap_done)
    begin
      st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
      if (st_r.cap_cnt == `BDS_CAP_WAIT)
      begin
        st_nxt.cap_done = 1'b1;
        st_nxt.special = ~pin_if.synced;
        st_nxt.act = ~pin_if.synced;
        st_nxt.security_off_flag = 1'b0;
        // unsecured part in special mode: enabled at once by the strap capture, without firmware
        st_nxt.en = ~pin_if.synced & ~i_flash_secured;
        if (~pin_if.synced & i_flash_secured)
        begin
          st_nxt.sec = BDS_SEC_CHECK;
        end
      end
    end
    else
    begin
      // host read and write, refused on a secured part
      if (i_hw_rd)
      begin
        st_nxt.rvalid = 1'b1;
        st_nxt.refused = locked;
        st_nxt.rdata = (hit && !locked) ? view : 8'h00;
      end
      if (i_hw_wr && hit && !locked)
      begin
        st_nxt.en = i_hw_wdata[`BDS_EN_BIT];
        st_nxt.shift_data_valid_flag = i_hw_wdata[`BDS_SDV_BIT];
        st_nxt.step = i_hw_wdata[`BDS_STEP_BIT];
        st_nxt.security_off_flag = i_hw_wdata[`BDS_SECURITY_OFF_FLAG_BIT];
      end
      else if (i_hw_wr && locked)
      begin
        st_nxt.refused = 1'b1;
      end

      // standard firmware may clear but never set the active flag
      if (i_fw_wr && st_r.act && st_r.sec != BDS_SEC_CHECK)
      begin
        st_nxt.en = i_fw_wdata[`BDS_EN_BIT];
        st_nxt.shift_data_valid_flag = i_fw_wdata[`BDS_SDV_BIT];
        st_nxt.step = i_fw_wdata[`BDS_STEP_BIT];
        if (!i_fw_wdata[`BDS_ACT_BIT])
        begin
          st_nxt.act = 1'b0;
        end
      end

      // secure firmware decides the erase check
      if (i_secfw_wr && st_r.special && st_r.sec == BDS_SEC_CHECK)
      begin
        st_nxt.en = i_secfw_wdata[`BDS_EN_BIT];
        st_nxt.security_off_flag = i_secfw_wdata[`BDS_SECURITY_OFF_FLAG_BIT];
        // erased: secure table off, standard table takes over
        st_nxt.sec = i_secfw_wdata[`BDS_SECURITY_OFF_FLAG_BIT] ? BDS_SEC_IDLE : BDS_SEC_LOCKED;
      end

      // activation only when enabled; refused requests leave no trace
      if (i_bgnd_req && st_r.en && !st_r.act)
      begin
        st_nxt.act = 1'b1;
      end

      if (i_resume_cmd)
      begin
        st_nxt.step = 1'b0;
      end
      if (i_step_cmd && st_r.act)
      begin
        st_nxt.step = 1'b1;
      end

      // clear first, so a completion in the same cycle wins
      if (i_cmd_rx || (st_r.act && !st_nxt.act))
      begin
        st_nxt.shift_data_valid_flag = 1'b0;
      end
      if (i_data_done)
      begin
        st_nxt.shift_data_valid_flag = 1'b1;
      end
    end

    // flag is meaningless when flash is configured unsecure
    st_nxt.sec_off = ~i_flash_secured | st_nxt.security_off_flag;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= '{en: 1'b0, act: 1'b0, shift_data_valid_flag: 1'b0, step: 1'b0, security_off_flag: 1'b0,
                cap_cnt: 2'h0, cap_done: 1'b0, special: 1'b0, sec: BDS_SEC_IDLE,
                sec_off: 1'b0, rdata: `BDS_RST_OTHER, rvalid: 1'b0, refused: 1'b0};
    end
    else if (i_clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_hw_rdata = st_r.rdata;
  assign o_hw_rvalid = st_r.rvalid;
  assign o_hw_refused = st_r.refused;
  assign o_debug_enable = st_r.en;
  assign o_debug_active = st_r.act;
  // the secure table overlays the standard one while the check runs
  assign o_fw_table_map = st_r.act & (st_r.sec == BDS_SEC_IDLE);
  assign o_sec_table_map = st_r.special & (st_r.sec == BDS_SEC_CHECK);
  assign o_security_off = st_r.sec_off;
  assign o_special_mode = st_r.special;
  assign o_status = view;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  chk_act_needs_en: assert property (
    i_clk_en && st_r.cap_done && !st_r.act && !st_r.en |=> !st_r.act)
    else $error("debug went active while disabled");

  chk_act_entry: assert property (
    i_clk_en && st_r.cap_done && i_bgnd_req && st_r.en && !st_r.act |=> st_r.act)
    else $error("enabled activation request not taken");

  chk_act_clear_src: assert property (
    i_clk_en && st_r.cap_done && st_r.act && !(i_fw_wr && !i_fw_wdata[`BDS_ACT_BIT]) |=> st_r.act)
    else $error("active flag dropped without firmware store");

  chk_sdv_set: assert property (
    i_clk_en && st_r.cap_done && i_data_done |=> o_status[`BDS_SDV_BIT])
    else $error("shift data valid not set after data phase");

  chk_sdv_clear: assert property (
    i_clk_en && st_r.cap_done && i_cmd_rx && !i_data_done && !i_hw_wr && !i_fw_wr
    |=> !o_status[`BDS_SDV_BIT])
    else $error("shift data valid not cleared by new command");

  chk_step_hold: assert property (
    i_clk_en && st_r.step && !i_resume_cmd && !i_hw_wr && !i_fw_wr |=> st_r.step)
    else $error("single-step flag dropped without resume");

  chk_locked_refuse: assert property (
    i_clk_en && st_r.cap_done && i_hw_rd && locked |=> o_hw_refused && o_hw_rdata == 8'h00)
    else $error("secured part answered a status read");

  chk_rsvd_zero: assert property (
    (o_status & ~`BDS_IMPL_MASK) == 8'h00)
    else $error("unimplemented status bit reads nonzero");

  chk_security_off_flag_view: assert property (
    !i_flash_secured |-> !o_status[`BDS_SECURITY_OFF_FLAG_BIT])
    else $error("unsecured flag visible on unsecured part");

  chk_sec_off: assert property (
    i_clk_en && !i_flash_secured && st_r.cap_done |=> o_security_off)
    else $error("security not off on unsecure flash");

  chk_special_start: assert property (
    i_clk_en && !st_r.cap_done && st_r.cap_cnt == `BDS_CAP_WAIT && !pin_if.synced && !i_flash_secured
    |=> st_r.en && st_r.act)
    else $error("special mode did not start enabled and active");

  ////////////////////////////////////////////////////////////////////////////
  // further checks; antecedents other than chk_sec_map wait for the strap capture, since earlier requests are ignored
  // every antecedent names the clock enable, so a frozen cycle never fires a check

  chk_step_set: assert property (
    i_clk_en && st_r.cap_done && st_r.act && i_step_cmd |=> st_r.step)
    else $error("single-step flag not set by step command");

  chk_step_exit: assert property (
    i_clk_en && st_r.cap_done && i_resume_cmd && !i_step_cmd |=> !st_r.step)
    else $error("single-step flag not cleared by resume");

  chk_sdv_exit: assert property (
    i_clk_en && st_r.cap_done && st_r.act && st_r.sec != BDS_SEC_CHECK && i_fw_wr
    && !i_fw_wdata[`BDS_ACT_BIT] && !i_data_done |=> !st_r.shift_data_valid_flag)
    else $error("shift data valid not cleared on debug exit");

  chk_fw_map: assert property (
    i_clk_en && st_r.cap_done && st_r.sec == BDS_SEC_IDLE && i_bgnd_req && st_r.en && !st_r.act
    |=> o_fw_table_map)
    else $error("firmware table not mapped on activation");

  chk_sec_map: assert property (
    i_clk_en && !st_r.cap_done && st_r.cap_cnt == `BDS_CAP_WAIT && !pin_if.synced && i_flash_secured
    |=> o_sec_table_map && !st_r.security_off_flag && !o_debug_enable)
    else $error("secured special start did not map the secure table");

  chk_erase_pass: assert property (
    i_clk_en && st_r.special && st_r.sec == BDS_SEC_CHECK && i_secfw_wr && i_secfw_wdata[`BDS_SECURITY_OFF_FLAG_BIT]
    |=> o_security_off && !o_sec_table_map)
    else $error("erased part not unsecured");

  chk_erase_fail: assert property (
    i_clk_en && st_r.special && st_r.sec == BDS_SEC_CHECK && i_secfw_wr && !i_secfw_wdata[`BDS_SECURITY_OFF_FLAG_BIT]
    |=> !st_r.security_off_flag && st_r.sec == BDS_SEC_LOCKED)
    else $error("failed erase check left the part unsecured");

  chk_security_off_flag_guard: assert property (
    i_clk_en && st_r.cap_done && locked && !(i_secfw_wr && st_r.special && st_r.sec == BDS_SEC_CHECK)
    |=> !st_r.security_off_flag)
    else $error("unsecured flag set outside the secure firmware");

  chk_locked_write: assert property (
    i_clk_en && st_r.cap_done && i_hw_wr && locked |=> o_hw_refused)
    else $error("secured part did not refuse a status write");

  chk_read_data: assert property (
    i_clk_en && st_r.cap_done && i_hw_rd && hit && !locked
    |=> o_hw_rvalid && !o_hw_refused && o_hw_rdata == $past(view))
    else $error("status read returned the wrong value");

  chk_other_addr: assert property (
    i_clk_en && st_r.cap_done && i_hw_rd && !hit |=> o_hw_rdata == 8'h00)
    else $error("read of another address returned data");

  chk_en_special: assert property (
    i_clk_en && st_r.special && st_r.sec == BDS_SEC_CHECK && i_secfw_wr && i_secfw_wdata[`BDS_EN_BIT]
    |=> o_debug_enable)
    else $error("secure firmware did not enable the debug unit");

  chk_act_hw_only: assert property (
    i_clk_en && st_r.cap_done && !st_r.act && !i_bgnd_req |=> !o_debug_active)
    else $error("active flag set without an activation request");

  chk_en_write: assert property (
    i_clk_en && st_r.cap_done && i_hw_wr && hit && !locked && !i_fw_wr && !i_secfw_wr
    |=> o_debug_enable == $past(i_hw_wdata[`BDS_EN_BIT]))
    else $error("host write did not set the enable flag");

  chk_rvalid_cause: assert property (
    i_clk_en && st_r.cap_done && !i_hw_rd |=> !o_hw_rvalid)
    else $error("read answer without a read command");

  chk_exit_map: assert property (
    i_clk_en && st_r.cap_done && st_r.act && st_r.sec != BDS_SEC_CHECK && i_fw_wr && !i_fw_wdata[`BDS_ACT_BIT]
    |=> !o_debug_active && !o_fw_table_map)
    else $error("debug memory still mapped after exit");

  cov_activate: cover property (st_r.en && i_bgnd_req ##1 st_r.act);
  cov_erase_ok: cover property (st_r.sec == BDS_SEC_CHECK ##1 st_r.sec == BDS_SEC_IDLE && st_r.security_off_flag);
  cov_step_resume: cover property (st_r.step ##[1:20] !st_r.step);
  cov_refused: cover property (o_hw_refused);
  cov_erase_fail: cover property (st_r.sec == BDS_SEC_CHECK ##1 st_r.sec == BDS_SEC_LOCKED);

endmodule

//--- hw/bds_regs.svh
// constants of the debug status register: address, bit positions, reset values, timing
`ifndef BDS_REGS_SVH
`define BDS_REGS_SVH

`define BDS_STATUS_ADDR 18'h3FF01
`define BDS_EN_BIT 7
`define BDS_ACT_BIT 6
`define BDS_SDV_BIT 4
`define BDS_STEP_BIT 3
`define BDS_SECURITY_OFF_FLAG_BIT 1
`define BDS_IMPL_MASK 8'hDA
`define BDS_RST_SPECIAL 8'h40
`define BDS_RST_OTHER 8'h00
`define BDS_CAP_WAIT 2'h3

`endif

//--- hw/bds_pkg.sv
// types shared by the debug status block
package bds_pkg;

  typedef enum logic [1:0]
  {
    BDS_SEC_IDLE = 2'b00,
    BDS_SEC_CHECK = 2'b01,
    BDS_SEC_LOCKED = 2'b10
  } bds_sec_t;

  typedef struct packed
  {
    logic en;
    logic act;
    logic shift_data_valid_flag;
    logic step;
    logic security_off_flag;
    logic [1:0] cap_cnt;
    logic cap_done;
    logic special;
    bds_sec_t sec;
    logic sec_off;
    logic [7:0] rdata;
    logic rvalid;
    logic refused;
  } bds_state_t;

endpackage

//--- hw/bds_sync_if.sv
// carries a raw pin level into the synchroniser and the clean level back
`timescale 1ns/1ps
interface bds_sync_if;
  logic raw;
  logic synced;
  modport sync
  (
    input raw,
    output synced
  );
  modport user
  (
    output raw,
    input synced
  );
endinterface

//--- hw/bds_sync.sv
// two-stage synchroniser for the debug wire pin level
`timescale 1ns/1ps
module bds_sync
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // pin level in, clean level out
  bds_sync_if.sync sif
);
  logic [1:0] stage_r;

  // the pin idles high, so both stages reset to 1
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stage_r <= 2'h3;
    end
    else if (i_clk_en)
    begin
      stage_r <= {stage_r[0], sif.raw};
    end
  end

  assign sif.synced = stage_r[1];
endmodule

//--- tb/bds_host_model.sv
// host model that sends register read and write commands over the debug link
`timescale 1ns/1ps
module bds_host_model
(
  // clock
  input wire logic i_clk_sys,
  // answers from the device
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_refused,
  // commands toward the device
  output logic o_cmd_rx,
  output logic o_rd,
  output logic o_wr,
  output logic [17:0] o_addr,
  output logic [7:0] o_wdata
);
  logic [7:0] rd_data;
  logic rd_ok;
  logic rd_ref;

  initial
  begin
    o_cmd_rx = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 18'h00000;
    o_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one command byte plus its data phase; answer taken one cycle later
  task automatic access(input logic wr, input logic [17:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_cmd_rx = 1'b1;
    o_rd = ~wr;
    o_wr = wr;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk_sys);
    o_cmd_rx = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    // released lines show a changing pattern, not the last value
    o_addr = ~a;
    o_wdata = ~d;
    rd_data = i_rdata;
    rd_ok = i_rvalid;
    rd_ref = i_refused;
  endtask
endmodule

//--- tb/tb_background_debug_status.sv
// self-checking bench for the debug status register
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_background_debug_status;
  localparam logic [17:0] STS = 18'h3FF01;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic pin = 1'b1;
  logic clk_en = 1'b1;
  logic fsec = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0] fw_wd = 8'h00;
  logic [7:0] sfw_wd = 8'h00;
  logic cmd_rx, hw_rd, hw_wr, rvalid, refused;
  logic [17:0] addr;
  logic [7:0] wdata, rdata, o_status;
  logic o_debug_enable, o_debug_active, o_fw_table_map, o_sec_table_map, o_security_off, o_special_mode;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int seed;
  logic [31:0] r;
  logic [17:0] ra;

  always #5 i_clk_sys = ~i_clk_sys;

  bds_host_model u_host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_rvalid(rvalid), .i_refused(refused),
    .o_cmd_rx(cmd_rx), .o_rd(hw_rd), .o_wr(hw_wr), .o_addr(addr), .o_wdata(wdata));

  bds_status u_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
    .i_debug_wire_pin(pin), .i_flash_secured(fsec), .i_cmd_rx(cmd_rx), .i_hw_rd(hw_rd),
    .i_hw_wr(hw_wr), .i_hw_addr(addr), .i_hw_wdata(wdata), .o_hw_rdata(rdata), .o_hw_rvalid(rvalid),
    .o_hw_refused(refused), .i_data_done(ev[0]), .i_bgnd_req(ev[1]), .i_step_cmd(ev[2]),
    .i_resume_cmd(ev[3]), .i_fw_wr(ev[4]), .i_fw_wdata(fw_wd), .i_secfw_wr(ev[5]),
    .i_secfw_wdata(sfw_wd), .o_debug_enable(o_debug_enable), .o_debug_active(o_debug_active),
    .o_fw_table_map(o_fw_table_map), .o_sec_table_map(o_sec_table_map),
    .o_security_off(o_security_off), .o_special_mode(o_special_mode), .o_status(o_status));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // expected status byte from the flag values; unimplemented bits always zero
  function automatic logic [7:0] exp_status(input logic en, input logic act, input logic shift_data_valid_flag, input logic step,
    input logic security_off_flag);
    exp_status = {en, act, 1'b0, shift_data_valid_flag, step, 1'b0, security_off_flag, 1'b0};
  endfunction

  // strap pin held well before release so the synchroniser settles
  task automatic do_reset(input logic p, input logic s);
    @(negedge i_clk_sys);
    pin = p;
    fsec = s;
    i_sys_rst = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    repeat (8) @(negedge i_clk_sys);
  endtask

  // one-cycle pulse on one progress or firmware input
  task automatic pulse(input int k);
    @(negedge i_clk_sys);
    ev = 6'h01 << k;
    @(negedge i_clk_sys);
    ev = 6'h00;
  endtask

  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h26A3;
    do_reset(1'b1, 1'b0);
    `CHK(o_status, 8'h00)
    `CHK(o_special_mode, 1'b0)
    pulse(1);
    `CHK(o_debug_active, 1'b0)
    u_host.access(1'b0, STS, 8'h00);
    `CHK(u_host.rd_ok, 1'b1)
    u_host.access(1'b1, STS, 8'h80);
    `CHK(o_status, 8'h80)
    pulse(1);
    `CHK(o_status, 8'hC0)
    `CHK(o_fw_table_map, 1'b1)
    pulse(0);
    `CHK(o_status[4], 1'b1)
    u_host.access(1'b0, STS, 8'h00);
    `CHK(u_host.rd_data[7:6], 2'b11)
    `CHK(o_status[4], 1'b0)
    pulse(2);
    `CHK(o_status[3], 1'b1)
    pulse(0);
    `CHK(o_status[3], 1'b1)
    pulse(3);
    `CHK(o_status[3], 1'b0)
    // host tries to drop the active flag; only the firmware store may
    u_host.access(1'b1, STS, 8'h80);
    `CHK(o_debug_active, 1'b1)
    pulse(0);
    fw_wd = 8'h80;
    pulse(4);
    `CHK(o_status, 8'h80)
    `CHK(o_fw_table_map, 1'b0)
    // a data phase during a frozen cycle must leave no trace
    clk_en = 1'b0;
    pulse(0);
    `CHK(o_status, 8'h80)
    clk_en = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      ra = 18'h3FF00 | {14'h0000, r[3:0]};
      if (ra == STS)
        ra = 18'h3FF02;
      u_host.access(1'b0, ra, 8'h00);
      `CHK(u_host.rd_data, 8'h00)
      u_host.access(1'b1, STS, {r[7], 7'h00});
      `CHK(o_debug_enable, r[7])
      `CHK(o_status, exp_status(r[7], 1'b0, 1'b0, 1'b0, 1'b0))
    end
    do_reset(1'b0, 1'b0);
    `CHK(o_special_mode, 1'b1)
    `CHK(o_status, 8'hC0)
    `CHK(o_security_off, 1'b1)
    do_reset(1'b0, 1'b1);
    `CHK(o_sec_table_map, 1'b1)
    `CHK(o_status[7], 1'b0)
    u_host.access(1'b0, STS, 8'h00);
    `CHK(u_host.rd_ref, 1'b1)
    `CHK(u_host.rd_data, 8'h00)
    u_host.access(1'b1, STS, 8'h82);
    `CHK(o_security_off, 1'b0)
    sfw_wd = 8'h82;
    pulse(5);
    `CHK(o_security_off, 1'b1)
    `CHK(o_sec_table_map, 1'b0)
    u_host.access(1'b0, STS, 8'h00);
    `CHK(u_host.rd_data, exp_status(1'b1, 1'b1, 1'b0, 1'b0, 1'b1))
    do_reset(1'b0, 1'b1);
    `CHK(o_security_off, 1'b0)
    sfw_wd = 8'h80;
    pulse(5);
    `CHK(o_debug_enable, 1'b1)
    `CHK(o_security_off, 1'b0)
    u_host.access(1'b0, STS, 8'h00);
    `CHK(u_host.rd_ref, 1'b1)
    tally_and_finish();
  end
endmodule
